/* hdl/ueb_pkg.sv */
/*
 * shared constants and types of the usb endpoint buffer block:
 * register map, control field layout, buffer offsets, states.
 * assumes a word-spaced register port with 16-bit data.
 */
`default_nettype none
package ueb_pkg;
    // ********************************************************
    // register map
    // ********************************************************
    localparam int         NUM_EP    = 5;
    localparam logic [7:0] OFS_MODE  = 8'h00;
    localparam logic [7:0] OFS_EP0   = 8'h10;
    localparam logic [7:0] OFS_END   = 8'h60;
    localparam logic [3:0] SUB_CTRL  = 4'h0;
    localparam logic [3:0] SUB_TLEN  = 4'h4;
    localparam logic [3:0] SUB_BASE  = 4'h8;
    localparam logic [15:0] MODE_MASK = 16'h3777;
    localparam int         MB_RX     = 0;
    localparam int         MB_TX     = 1;
    localparam int         MB_DUAL   = 2;
    localparam int         MB_STRIDE = 4;
    // ********************************************************
    // control register fields
    // ********************************************************
    localparam int         TOG_OUT   = 7;
    localparam int         TOG_IN    = 6;
    localparam int         AUTO_FLIP = 4;
    localparam int         OUT_HS    = 2;
    localparam int         IN_RSP    = 0;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'hdf;
    localparam logic [7:0] TLEN_RST  = 8'h00;
    // ********************************************************
    // buffer layout
    // ********************************************************
    localparam logic [7:0]  BUF_BYTES = 8'h40;
    localparam logic [14:0] HALF_OFS  = 15'h0040;
    localparam logic [14:0] TXD_OFS   = 15'h0080;
    localparam logic [14:0] EP4_RX    = 15'h0040;
    localparam logic [14:0] EP4_TX    = 15'h0080;
    typedef enum logic [1:0] {
        RSP_ACK   = 2'b00,
        RSP_NONE  = 2'b01,
        RSP_NAK   = 2'b10,
        RSP_STALL = 2'b11
    } ueb_rsp_e;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RX    = 3'b001,
        ST_FETCH = 3'b010,
        ST_LOAD  = 3'b011,
        ST_SEND  = 3'b100,
        ST_WAIT  = 3'b101
    } ueb_state_e;
endpackage : ueb_pkg
`default_nettype wire

/* hdl/ueb_endpoint_buffers.sv */
/*
 * usb device endpoint buffers: registers, buffer address choice,
 * data toggles, response choice and byte moves to buffer memory.
 * assumes a packet engine on the same clock and a byte memory
 * that answers a read one cycle after mem_re_o.
 */
// Decided for this implementation: the register offsets and the strobed register port.
`default_nettype none
// Function
// - endpoints 1-3 layout from enables and mode; both off means no memory use
// - receive only, single: one 64-byte out buffer at start address
// - receive only, dual: two out buffers picked by out toggle
// - transmit only, single: one 64-byte in buffer at start address
// - transmit only, dual: two in buffers picked by in toggle
// - both single: out buffer at start, in buffer 64 bytes later
// - both dual: out halves at 0 and 64, in halves at 128 and 192
// - toggle 0 picks lower half, toggle 1 picks upper half
// - auto flip makes the halves alternate without software
// - start address keeps low 15 bits, aligned to 4 bytes
// - transmit length register gives bytes sent in next in data, values above 64 send 64
// - control bit 7 is expected out data pid, resets to 0
// - control bit 6 is sent in data pid, resets to 0
// - bit 4 flips the toggle after each successful transfer
// - auto flip only on endpoints 1, 2 and 3
// - bits 3:2 pick out answer: ack, none, nak, stall
// - bits 1:0 pick in answer: data, data no handshake, nak, stall
// - endpoint 4 buffers sit 64 and 128 after endpoint 0 start
module ueb_endpoint_buffers (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic        tok_valid_i,
    input  wire logic [2:0]  tok_ep_i,
    input  wire logic        tok_in_i,
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_end_i,
    input  wire logic        rx_ok_i,
    input  wire logic        rx_pid_tog_i,
    input  wire logic        tx_ready_i,
    output logic             tx_valid_o,
    output logic      [7:0]  tx_data_o,
    output logic             tx_done_o,
    output logic             tx_pid_tog_o,
    input  wire logic        hs_ack_i,
    input  wire logic        hs_timeout_i,
    output logic             resp_valid_o,
    output logic      [1:0]  resp_code_o,
    output logic      [6:0]  rx_len_o,
    output logic      [14:0] mem_addr_o,
    output logic      [7:0]  mem_wdata_o,
    output logic             mem_we_o,
    output logic             mem_re_o,
    input  wire logic [7:0]  mem_rdata_i
);
    localparam int NE = ueb_pkg::NUM_EP;
    // ********************************************************
    // register file
    // ********************************************************
    logic [15:0]   mode_ff;
    logic [7:0]    ctrl_w [NE];
    logic [7:0]    tlen_w [NE];
    logic [12:0]   base_w [NE];
    logic [14:0]   rx_start [NE];
    logic [14:0]   tx_start [NE];
    logic [14:0]   ep_org [NE];
    logic [2:0]    ep_mode [NE];
    logic [NE-1:0] wr_ctrl;
    logic [NE-1:0] rx_en;
    logic [NE-1:0] tx_en;
    logic [NE-1:0] auto_ok;
    logic [7:0]    rel_a;
    logic [2:0]    epi;
    logic          in_ep;
    logic [15:0]   nxt_rdata;
    logic [15:0]   rdata_ff;
    logic          flip_out_ev;
    logic          flip_in_ev;
    ueb_pkg::ueb_state_e state_ff;
    logic [2:0]    cur_ep_ff;

    assign rel_a = reg_addr_i - ueb_pkg::OFS_EP0;
    assign epi   = rel_a[6:4];
    assign in_ep = (reg_addr_i >= ueb_pkg::OFS_EP0) && (reg_addr_i < ueb_pkg::OFS_END);

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            mode_ff <= '0;
        else if (reg_wr_i && (reg_addr_i == ueb_pkg::OFS_MODE))
            mode_ff <= reg_wdata_i & ueb_pkg::MODE_MASK;
    end

    generate
        for (genvar i = 0; i < NE; i++)
        begin : g_ep
            localparam logic [2:0] IDX = 3'(i);
            logic [7:0]  c_ff;
            logic [7:0]  t_ff;
            logic [12:0] b_ff;
            logic [2:0]  m;
            logic        wr_t;
            logic        wr_b;
            assign wr_ctrl[i] = reg_wr_i && in_ep && (epi == IDX)
                                && (reg_addr_i[3:0] == ueb_pkg::SUB_CTRL);
            assign wr_t = reg_wr_i && in_ep && (epi == IDX)
                          && (reg_addr_i[3:0] == ueb_pkg::SUB_TLEN);
            assign wr_b = reg_wr_i && in_ep && (epi == IDX) && (i < NE - 1)
                          && (reg_addr_i[3:0] == ueb_pkg::SUB_BASE);
            assign ctrl_w[i]  = c_ff;
            assign tlen_w[i]  = t_ff;
            assign base_w[i]  = b_ff;
            assign ep_mode[i] = m;
            assign rx_en[i]   = m[ueb_pkg::MB_RX];
            assign tx_en[i]   = m[ueb_pkg::MB_TX];
            if (i == 0)
            begin : g_ep0
                // shared single buffer for both directions
                assign m           = 3'b011;
                assign ep_org[i]   = {b_ff, 2'b00};
                assign rx_start[i] = ep_org[i];
                assign tx_start[i] = ep_org[i];
                assign auto_ok[i]  = 1'b0;
            end
            else if (i == NE - 1)
            begin : g_ep4
                assign m           = {1'b0, mode_ff[ueb_pkg::MB_STRIDE*(i-1) +: 2]};
                assign ep_org[i]   = ep_org[0];
                assign rx_start[i] = ep_org[0] + ueb_pkg::EP4_RX;
                assign tx_start[i] = ep_org[0] + ueb_pkg::EP4_TX;
                assign auto_ok[i]  = 1'b0;
            end
            else
            begin : g_ep13
                logic [14:0] rx_half;
                logic [14:0] tx_half;
                logic [14:0] tx_skip;
                assign m         = mode_ff[ueb_pkg::MB_STRIDE*(i-1) +: 3];
                assign ep_org[i] = {b_ff, 2'b00};
                assign rx_half = m[ueb_pkg::MB_DUAL]
                                 ? {8'h00, c_ff[ueb_pkg::TOG_OUT], 6'h00} : '0;
                assign tx_half = m[ueb_pkg::MB_DUAL]
                                 ? {8'h00, c_ff[ueb_pkg::TOG_IN], 6'h00} : '0;
                // the in region follows the out region when both are on
                assign tx_skip = !m[ueb_pkg::MB_RX] ? '0
                                 : (m[ueb_pkg::MB_DUAL] ? ueb_pkg::TXD_OFS
                                                        : ueb_pkg::HALF_OFS);
                assign rx_start[i] = ep_org[i] + rx_half;
                assign tx_start[i] = ep_org[i] + tx_skip + tx_half;
                assign auto_ok[i]  = c_ff[ueb_pkg::AUTO_FLIP];
            end

            always_ff @(posedge ref_clk_i)
            begin
                if (!nrst_i)
                    c_ff <= ueb_pkg::CTRL_RST;
                else
                begin
                    if (wr_ctrl[i])
                        c_ff <= reg_wdata_i[7:0] & ueb_pkg::CTRL_MASK;
                    // a flip in the write cycle wins over the written toggle
                    if (flip_out_ev && (cur_ep_ff == IDX) && auto_ok[i])
                        c_ff[ueb_pkg::TOG_OUT] <= ~c_ff[ueb_pkg::TOG_OUT];
                    if (flip_in_ev && (cur_ep_ff == IDX) && auto_ok[i])
                        c_ff[ueb_pkg::TOG_IN] <= ~c_ff[ueb_pkg::TOG_IN];
                end
            end

            always_ff @(posedge ref_clk_i)
            begin
                if (!nrst_i)
                    t_ff <= ueb_pkg::TLEN_RST;
                else if (wr_t)
                    t_ff <= reg_wdata_i[7:0];
            end

            always_ff @(posedge ref_clk_i)
            begin
                if (!nrst_i)
                    b_ff <= '0;
                else if (wr_b)
                    b_ff <= reg_wdata_i[14:2];
            end
        end
    endgenerate

    always_comb
    begin
        nxt_rdata = '0;
        if (reg_addr_i == ueb_pkg::OFS_MODE)
            nxt_rdata = mode_ff;
        else if (in_ep && (reg_addr_i[3:0] == ueb_pkg::SUB_CTRL))
            nxt_rdata = {8'h00, ctrl_w[epi]};
        else if (in_ep && (reg_addr_i[3:0] == ueb_pkg::SUB_TLEN))
            nxt_rdata = {8'h00, tlen_w[epi]};
        else if (in_ep && (reg_addr_i[3:0] == ueb_pkg::SUB_BASE) && (epi < 3'(NE - 1)))
            nxt_rdata = {1'b0, base_w[epi], 2'b00};
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            rdata_ff <= '0;
        else
            rdata_ff <= reg_rd_i ? nxt_rdata : '0;
    end
    assign reg_rdata_o = rdata_ff;

    // ********************************************************
    // transaction engine
    // ********************************************************
    logic [14:0] addr_ff;
    logic [6:0]  cnt_ff;
    logic [6:0]  len_ff;
    logic [1:0]  sel_ff;
    logic [7:0]  tok_ctrl;
    logic [7:0]  tok_tlen;
    logic [6:0]  tok_len;
    logic [7:0]  cur_ctrl;
    logic        tok_ok;
    logic        rx_take;
    logic        rx_good;
    logic        tx_take;
    logic        last_take;
    logic        resp_ff;
    logic [1:0]  code_ff;
    logic        done_ff;
    logic        tog_ff;
    logic [7:0]  txd_ff;
    logic [6:0]  rxl_ff;

    assign tok_ctrl = ctrl_w[tok_ep_i];
    assign tok_tlen = tlen_w[tok_ep_i];
    assign cur_ctrl = ctrl_w[cur_ep_ff];
    // a disabled direction or endpoint never reaches buffer memory
    assign tok_ok = tok_valid_i && (state_ff == ueb_pkg::ST_IDLE) && (tok_ep_i < 3'(NE))
                    && (tok_in_i ? tx_en[tok_ep_i] : rx_en[tok_ep_i]);
    assign tok_len = (tok_tlen > ueb_pkg::BUF_BYTES) ? ueb_pkg::BUF_BYTES[6:0]
                                                     : tok_tlen[6:0];
    // bytes past 64 are dropped, so an undersized buffer is the user's loss
    assign rx_take = (state_ff == ueb_pkg::ST_RX) && rx_valid_i && !sel_ff[1]
                     && (cnt_ff < ueb_pkg::BUF_BYTES[6:0]);
    assign rx_good = (state_ff == ueb_pkg::ST_RX) && rx_end_i && rx_ok_i && !sel_ff[1];
    assign flip_out_ev = rx_good && (rx_pid_tog_i == cur_ctrl[ueb_pkg::TOG_OUT]);
    assign tx_take   = (state_ff == ueb_pkg::ST_SEND) && tx_ready_i;
    assign last_take = tx_take && (7'(cnt_ff + 7'h01) == len_ff);
    // no handshake to wait for in the isochronous case
    assign flip_in_ev = (state_ff == ueb_pkg::ST_WAIT)
                        && (hs_ack_i || (sel_ff == ueb_pkg::RSP_NONE));

    assign mem_we_o    = rx_take;
    assign mem_re_o    = (state_ff == ueb_pkg::ST_FETCH);
    assign mem_addr_o  = addr_ff + {8'h00, cnt_ff};
    assign mem_wdata_o = rx_data_i;
    assign tx_valid_o  = (state_ff == ueb_pkg::ST_SEND);

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            state_ff  <= ueb_pkg::ST_IDLE;
            cur_ep_ff <= '0;
            addr_ff   <= '0;
            cnt_ff    <= '0;
            len_ff    <= '0;
            sel_ff    <= '0;
        end
        else
        begin
            case (state_ff)
                ueb_pkg::ST_IDLE:
                    if (tok_ok)
                    begin
                        cur_ep_ff <= tok_ep_i;
                        cnt_ff    <= '0;
                        len_ff    <= tok_len;
                        if (tok_in_i)
                        begin
                            sel_ff  <= tok_ctrl[ueb_pkg::IN_RSP +: 2];
                            addr_ff <= tx_start[tok_ep_i];
                            if (!tok_ctrl[ueb_pkg::IN_RSP + 1])
                                state_ff <= (tok_len == '0) ? ueb_pkg::ST_WAIT
                                                            : ueb_pkg::ST_FETCH;
                        end
                        else
                        begin
                            sel_ff   <= tok_ctrl[ueb_pkg::OUT_HS +: 2];
                            addr_ff  <= rx_start[tok_ep_i];
                            state_ff <= ueb_pkg::ST_RX;
                        end
                    end
                ueb_pkg::ST_RX:
                begin
                    if (rx_take)
                        cnt_ff <= 7'(cnt_ff + 7'h01);
                    if (rx_end_i)
                        state_ff <= ueb_pkg::ST_IDLE;
                end
                ueb_pkg::ST_FETCH:
                    state_ff <= ueb_pkg::ST_LOAD;
                ueb_pkg::ST_LOAD:
                    state_ff <= ueb_pkg::ST_SEND;
                ueb_pkg::ST_SEND:
                    if (tx_take)
                    begin
                        cnt_ff   <= 7'(cnt_ff + 7'h01);
                        state_ff <= last_take ? ueb_pkg::ST_WAIT : ueb_pkg::ST_FETCH;
                    end
                ueb_pkg::ST_WAIT:
                    if (flip_in_ev || hs_timeout_i)
                        state_ff <= ueb_pkg::ST_IDLE;
                default:
                    state_ff <= ueb_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            resp_ff <= 1'b0;
            code_ff <= '0;
            done_ff <= 1'b0;
            tog_ff  <= 1'b0;
            txd_ff  <= '0;
            rxl_ff  <= '0;
        end
        else
        begin
            resp_ff <= 1'b0;
            done_ff <= last_take;
            if (tok_ok && tok_in_i)
            begin
                tog_ff <= tok_ctrl[ueb_pkg::TOG_IN];
                if (tok_ctrl[ueb_pkg::IN_RSP + 1])
                begin
                    resp_ff <= 1'b1;
                    code_ff <= tok_ctrl[ueb_pkg::IN_RSP +: 2];
                end
                else if (tok_len == '0)
                    done_ff <= 1'b1;
            end
            if ((state_ff == ueb_pkg::ST_RX) && rx_end_i && rx_ok_i)
            begin
                resp_ff <= 1'b1;
                code_ff <= sel_ff;
            end
            if (state_ff == ueb_pkg::ST_LOAD)
                txd_ff <= mem_rdata_i;
            if (flip_out_ev)
                rxl_ff <= cnt_ff;
        end
    end
    assign resp_valid_o = resp_ff;
    assign resp_code_o  = code_ff;
    assign tx_done_o    = done_ff;
    assign tx_pid_tog_o = tog_ff;
    assign tx_data_o    = txd_ff;
    assign rx_len_o     = rxl_ff;

    // ********************************************************
    // checks
    // ********************************************************
    logic [14:0] rel;
    logic [2:0]  mc;
    logic        ep13;
    logic [6:0]  chk_ff;
    logic        tog_in_cur;
    assign rel  = mem_addr_o - ep_org[cur_ep_ff];
    assign mc   = ep_mode[cur_ep_ff];
    assign ep13 = (cur_ep_ff != 3'h0) && (cur_ep_ff < 3'(NE - 1));
    assign tog_in_cur = cur_ctrl[ueb_pkg::TOG_IN];
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i || tok_ok)
            chk_ff <= '0;
        else if (tx_take)
            chk_ff <= 7'(chk_ff + 7'h01);
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    a_off_no_mem: assert property ((mem_we_o || mem_re_o) && ep13 |-> mc[1:0] != 2'b00)
        else $error("buffer touched on disabled endpoint");
    a_rx_single_half: assert property (mem_we_o && ep13 && !mc[2] |-> rel < 15'h0040)
        else $error("single out write outside first 64 bytes");
    a_rx_dual_half: assert property (mem_we_o && ep13 && mc[2]
        |-> rel[14:6] == {8'h00, cur_ctrl[ueb_pkg::TOG_OUT]})
        else $error("dual out write in wrong half");
    a_tx_single_area: assert property (mem_re_o && ep13 && !mc[2]
        |-> rel[14:6] == {8'h00, mc[0]})
        else $error("single in read at wrong offset");
    a_tx_dual_area: assert property (mem_re_o && ep13 && mc[2]
        |-> rel[14:6] == {7'h00, mc[0], tog_in_cur})
        else $error("dual in read at wrong offset");
    a_ep4_layout: assert property ((mem_we_o || mem_re_o) && (cur_ep_ff == 3'h4)
        |-> rel[14:6] == {7'h00, mem_re_o, mem_we_o})
        else $error("endpoint 4 buffer misplaced");
    a_base_aligned: assert property (reg_rd_i && in_ep && (reg_addr_i[3:0] == 4'h8)
        |=> reg_rdata_o[1:0] == 2'b00 && !reg_rdata_o[15])
        else $error("start address not 15-bit aligned");
    // chk_ff has already counted the last take when done shows, zero length too
    a_tlen_count: assert property (tx_done_o |-> chk_ff == len_ff)
        else $error("in payload length mismatch");
    a_ctrl_reset: assert property (disable iff (1'b0) !nrst_i |=> ctrl_w[1] == 8'h00)
        else $error("control not cleared by reset");
    a_auto_flip: assert property ((state_ff == ueb_pkg::ST_WAIT) && hs_ack_i && auto_ok[cur_ep_ff]
        && !wr_ctrl[cur_ep_ff] |=> tog_in_cur != $past(tog_in_cur))
        else $error("in toggle did not flip");
    a_ep0_sw_only: assert property (!$stable(ctrl_w[0]) |-> $past(wr_ctrl[0]))
        else $error("endpoint 0 toggle changed by hardware");
    a_out_answer: assert property ((state_ff == ueb_pkg::ST_RX) && rx_end_i && rx_ok_i
        |=> resp_valid_o && resp_code_o == $past(sel_ff))
        else $error("out answer does not follow select");
    a_in_refuse: assert property (tok_ok && tok_in_i && tok_ctrl[1]
        |=> resp_valid_o && !tx_valid_o ##1 !tx_valid_o)
        else $error("nak or stall in sent data");

    c_out_ack: cover property (rx_good && sel_ff == 2'b00 ##1 resp_valid_o);
    c_in_dual: cover property (tx_done_o && mc[2] ##[1:8] flip_in_ev);
    c_iso_in: cover property ((state_ff == ueb_pkg::ST_WAIT) && sel_ff == 2'b01);
endmodule : ueb_endpoint_buffers
`default_nettype wire

/* verification/ueb_far_model.sv */
/*
 * far-side model: byte memory behind the buffer port and the tx byte sink.
 * assumes the block's clock; read data stand one cycle after mem_re_i.
 */
`default_nettype none
module ueb_far_model (
    input  wire logic        ref_clk_i,
    input  wire logic [14:0] mem_addr_i,
    input  wire logic        mem_re_i,
    input  wire logic        stall_i,
    output logic      [7:0]  mem_rdata_o = 8'h00,
    output logic             tx_ready_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle read bus flips every cycle so stale data never matches
    always_ff @(posedge ref_clk_i)
    begin
        mem_rdata_o <= mem_re_i ? (mem_addr_i[7:0] ^ 8'ha5) : ~mem_rdata_o;
        tx_ready_o  <= ~stall_i;
    end
endmodule : ueb_far_model
`default_nettype wire

/* verification/tb.sv */
/*
 * self-checking bench: register port, out and in transfers, responses.
 * assumes ueb_far_model answers memory reads and stalls the tx sink.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, tok_valid_i = 0, tok_in_i = 0;
    logic rx_valid_i = 0, rx_end_i = 0, rx_ok_i = 0, rx_pid_tog_i = 0, hs_ack_i = 0, stall = 0;
    logic hs_to = 0, use_to = 0;
    logic [7:0] reg_addr_i = 0, rx_data_i = 0, tx_data_o, mem_wdata_o, mem_rdata_i;
    logic [15:0] reg_wdata_i = 0, reg_rdata_o;
    logic [2:0] tok_ep_i = 0;
    logic tx_valid_o, tx_done_o, tx_pid_tog_o, resp_valid_o, mem_we_o, mem_re_o, tx_ready_i;
    logic [1:0] resp_code_o;
    logic [6:0] rx_len_o;
    logic [14:0] mem_addr_o, b;
    logic [31:0] seed = 32'd84454;
    int n_errors = 0, comparisons = 0;
    ueb_endpoint_buffers i_dut (.ref_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .tok_valid_i, .tok_ep_i, .tok_in_i, .rx_valid_i, .rx_data_i,
        .rx_end_i, .rx_ok_i, .rx_pid_tog_i, .tx_ready_i, .tx_valid_o, .tx_data_o, .tx_done_o,
        .tx_pid_tog_o, .hs_ack_i, .hs_timeout_i(hs_to), .resp_valid_o, .resp_code_o, .rx_len_o,
        .mem_addr_o, .mem_wdata_o, .mem_we_o, .mem_re_o, .mem_rdata_i);
    ueb_far_model i_far (.ref_clk_i, .mem_addr_i(mem_addr_o), .mem_re_i(mem_re_o),
        .stall_i(stall), .mem_rdata_o(mem_rdata_i), .tx_ready_o(tx_ready_i));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [7:0] pat(input logic [14:0] a);
        return a[7:0] ^ 8'ha5;
    endfunction : pat
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic finish_test;
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1;
        @(posedge ref_clk_i);
        reg_wr_i <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1;
        @(posedge ref_clk_i);
        reg_rd_i <= 0;
        @(negedge ref_clk_i);
        chk(reg_rdata_o, e);
    endtask : rd
    task automatic tok(input logic [2:0] ep, input logic dir);
        @(posedge ref_clk_i);
        tok_valid_i <= 1;
        tok_ep_i <= ep;
        tok_in_i <= dir;
        @(posedge ref_clk_i);
        tok_valid_i <= 0;
    endtask : tok
    task automatic out_tx(input logic [2:0] ep, input logic p, ok, we, rv,
                          input logic [14:0] a, input logic [1:0] c);
        logic [7:0] d;
        tok(ep, 0);
        rx_valid_i <= 1;
        d = 8'(xs());
        rx_data_i <= d;
        @(negedge ref_clk_i);
        chk(mem_we_o, we);
        if (we)
        begin
            chk(mem_addr_o, a);
            chk(16'(mem_wdata_o), 16'(d));
        end
        @(posedge ref_clk_i);
        rx_valid_i <= 0;
        rx_end_i <= 1;
        rx_ok_i <= ok;
        rx_pid_tog_i <= p;
        @(posedge ref_clk_i);
        rx_end_i <= 0;
        @(negedge ref_clk_i);
        chk(resp_valid_o, rv);
        if (rv)
        begin
            chk(resp_code_o, c);
            if (we)
                chk(16'(rx_len_o), 16'h0001);
        end
    endtask : out_tx
    task automatic in_tx(input logic [2:0] ep, input logic [14:0] a, input int n,
                         input logic tg, input logic [1:0] c);
        int k;
        k = 0;
        tok(ep, 1);
        @(negedge ref_clk_i);
        if (c[1])
        begin
            chk(resp_valid_o, 1);
            chk(resp_code_o, c);
            return;
        end
        chk(tx_pid_tog_o, tg);
        repeat (400)
        begin
            if (mem_re_o)
                chk(mem_addr_o, 16'(a + k));
            if (tx_valid_o && tx_ready_i)
            begin
                chk(tx_data_o, pat(15'(a + k)));
                k++;
            end
            if (tx_done_o === 1'b1)
                break;
            @(negedge ref_clk_i);
        end
        chk(tx_done_o, 1);
        chk(16'(k), 16'(n));
        @(posedge ref_clk_i);
        hs_ack_i <= !use_to;
        hs_to <= use_to;
        @(posedge ref_clk_i);
        hs_ack_i <= 0;
        hs_to <= 0;
    endtask : in_tx
    initial
    begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // sink stalls about one cycle in four
    always @(posedge ref_clk_i) stall <= (xs() & 32'h3) == 0;
    initial
    begin
        repeat (8000) @(posedge ref_clk_i);
        n_errors++;
        finish_test;
    end
    initial
    begin
        repeat (12) @(posedge ref_clk_i);
        nrst_i <= 1;
        rd(8'h20, 16'h0000);
        rd(8'h58, 16'h0000);
        wr(8'h28, 16'hffff);
        rd(8'h28, 16'h7ffc);
        // aligned base with room for 256 bytes, each region 64 bytes
        b = 15'(xs()) & 15'h3ffc;
        wr(8'h28, {1'b0, b});
        wr(8'h00, 16'h0007);
        wr(8'h20, 16'h0010);
        wr(8'h24, 16'h0002);
        out_tx(1, 0, 1, 1, 1, b, 0);
        rd(8'h20, 16'h0090);
        out_tx(1, 1, 1, 1, 1, b + 15'h40, 0);
        in_tx(1, b + 15'h80, 2, 0, 0);
        in_tx(1, b + 15'hc0, 2, 1, 0);
        rd(8'h20, 16'h0010);
        wr(8'h00, 16'h0003);
        out_tx(1, 0, 1, 1, 1, b, 0);
        // timeout instead of ack: the in toggle must stay put
        use_to = 1;
        in_tx(1, b + 15'h40, 2, 0, 0);
        use_to = 0;
        rd(8'h20, 16'h0090);
        for (int c = 1; c < 4; c++)
        begin
            wr(8'h20, 16'(c << 2));
            out_tx(1, 0, 1, c < 2, 1, b, 2'(c));
            wr(8'h20, 16'(c));
            in_tx(1, c > 1 ? b : b + 15'h40, c > 1 ? 0 : 2, 0, 2'(c));
        end
        wr(8'h20, 16'h0000);
        out_tx(1, 0, 0, 1, 0, b, 0);
        wr(8'h18, {1'b0, b});
        wr(8'h00, 16'h3000);
        wr(8'h54, 16'h0001);
        wr(8'h50, 16'h0010);
        out_tx(4, 0, 1, 1, 1, b + 15'h40, 0);
        rd(8'h50, 16'h0010);
        in_tx(4, b + 15'h80, 1, 0, 0);
        wr(8'h54, 16'h0000);
        in_tx(4, b + 15'h80, 0, 0, 0);
        out_tx(2, 0, 1, 0, 0, b, 0);
        finish_test;
    end
endmodule : tb
`default_nettype wire
